// ==== rtl/tsq_top.sv ====
// Operation
// - Bit 15 switches the whole trigger sequencer on or off and resets to zero.
// - With bit 13 set the sequencer freezes while the device is idle and the watchdog count restarts from zero, else it runs on.
// - With bit 12 set each trigger-output command inverts the addressed output.
// - With bit 12 clear each trigger-output command pulses the output for the set width plus one cycle.
// - Writing one to bit 10 raises a software trigger; writing zero does nothing.
// - The software trigger is only consumed by the control-step command.
// - Bit 9 turns single-step execution on or off; meant for debug tools.
// - With bit 8 set, step-delay, loop and timer limit reads return the live counter or timer value; the watchdog limit reads its written value.
// - With bit 8 clear, limit-register reads return the last written limit.
// - Bit 7 set runs commands one after another; clearing it stops execution once the sequencer next returns to idle.
// - Bit 6 is set when the sequencer watchdog expires and stays set until a zero is written to it.
// - Only hardware sets bit 6, and it resets to zero.
// - The two low bits only shape the wait-for-input-high and -low commands.
// - Bits 14, 11 and 5 to 2 read as zero and ignore writes.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module tsq_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tsq_pkg::AW-1:0]      paddr,
  input  wire logic [tsq_pkg::DW-1:0]      pwdata,
  output logic      [tsq_pkg::DW-1:0]      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire tsq_pkg::tsq_op_t            cmd_op,
  input  wire logic [tsq_pkg::ARG_W-1:0]   cmd_arg,
  input  wire logic [tsq_pkg::N_IO-1:0]    wait_in,
  input  wire logic                        idle_mode,
  output logic      [tsq_pkg::N_IO-1:0]    trig_out,
  output logic                             irq
);
  import tsq_pkg::*;

  tsq_ctl_if c ();

  tsq_exec u_exec (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (c.exec_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control/status bits
  logic             en_reg,   en_next;
  logic             sidl_reg, sidl_next;
  logic             togl_reg, togl_next;
  logic             swt_reg,  swt_next;
  logic             ssen_reg, ssen_next;
  logic             ivis_reg, ivis_next;
  logic             strt_reg, strt_next;
  logic             wdto_reg, wdto_next;
  logic [1:0]       itm_reg,  itm_next;
  // limits and settings
  logic [LIM_W-1:0] sdlim_reg, sdlim_next;
  logic [LIM_W-1:0] clim_reg,  clim_next;
  logic [LIM_W-1:0] tlim_reg,  tlim_next;
  logic [LIM_W-1:0] wdlim_reg, wdlim_next;
  logic [PWD_W-1:0] pwd_reg,   pwd_next;
  logic [IRQ_W-1:0] istat_reg, istat_next;
  logic [IRQ_W-1:0] ien_reg,   ien_next;
  // live state
  logic [LIM_W-1:0] lcnt_reg,  lcnt_next;
  logic [LIM_W-1:0] wcnt_reg,  wcnt_next;
  logic [N_IO-1:0]  out_reg,   out_next;
  logic [PWD_W-1:0] pcnt_reg [N_IO];
  logic [PWD_W-1:0] pcnt_next [N_IO];
  logic [DW-1:0]    rdata_reg, rdata_next;
  logic             err_reg,   err_next;

  logic             wr;
  logic             setup;
  logic             wr_cst;
  logic [CST_W-1:0] cst_rd;
  logic [IRQ_W-1:0] ev;

  function automatic logic mapped(input logic [AW-1:0] a);
    case (a)
      OFS_CST, OFS_SDLIM, OFS_CLIM, OFS_TLIM, OFS_PWD,
      OFS_WDLIM, OFS_ISTAT, OFS_ICLR, OFS_IEN, OFS_OUT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg;
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & mapped(paddr);
  assign wr_cst  = wr && paddr == OFS_CST;

  assign c.en        = en_reg;
  assign c.run       = strt_reg;
  assign c.halt      = sidl_reg & idle_mode;
  assign c.in_mode   = itm_reg;
  assign c.sd_lim    = sdlim_reg;
  assign c.t_lim     = tlim_reg;
  assign c.swt_pend  = swt_reg;
  assign c.cmd_valid = cmd_valid;
  assign c.cmd_op    = cmd_op;
  assign c.cmd_arg   = cmd_arg;
  assign c.wait_in   = wait_in;
  assign cmd_ready   = c.cmd_ready;
  // watchdog fires only while a wait command is pending
  assign c.wdt_hit   = c.waiting && wcnt_reg >= wdlim_reg;
  assign trig_out    = out_reg;
  assign irq         = |(istat_reg & ien_reg);

  always_comb begin
    cst_rd         = '0;
    cst_rd[B_EN]   = en_reg;
    cst_rd[B_SIDL] = sidl_reg;
    cst_rd[B_TOGL] = togl_reg;
    cst_rd[B_SWT]  = swt_reg;
    cst_rd[B_SSEN] = ssen_reg;
    cst_rd[B_IVIS] = ivis_reg;
    cst_rd[B_STRT] = strt_reg;
    cst_rd[B_WDTO] = wdto_reg;
    cst_rd[B_ITM+1:B_ITM] = itm_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    en_next    = en_reg;
    sidl_next  = sidl_reg;
    togl_next  = togl_reg;
    ssen_next  = ssen_reg;
    ivis_next  = ivis_reg;
    itm_next   = itm_reg;
    sdlim_next = sdlim_reg;
    clim_next  = clim_reg;
    tlim_next  = tlim_reg;
    wdlim_next = wdlim_reg;
    pwd_next   = pwd_reg;
    ien_next   = ien_reg;
    if (wr_cst) begin
      en_next   = pwdata[B_EN];
      sidl_next = pwdata[B_SIDL];
      togl_next = pwdata[B_TOGL];
      ssen_next = pwdata[B_SSEN];
      ivis_next = pwdata[B_IVIS];
      itm_next  = pwdata[B_ITM+1:B_ITM];
    end
    if (wr) begin
      case (paddr)
        OFS_SDLIM: sdlim_next = pwdata[LIM_W-1:0];
        OFS_CLIM:  clim_next  = pwdata[LIM_W-1:0];
        OFS_TLIM:  tlim_next  = pwdata[LIM_W-1:0];
        OFS_WDLIM: wdlim_next = pwdata[LIM_W-1:0];
        OFS_PWD:   pwd_next   = pwdata[PWD_W-1:0];
        OFS_IEN:   ien_next   = pwdata[IRQ_W-1:0];
        default:   ien_next   = ien_reg;
      endcase
    end
    // software trigger: a zero write cannot clear it; consumption clears it
    swt_next = (wr_cst & pwdata[B_SWT]) | (swt_reg & ~c.swt_take);
    // single step drops the run bit after each command; a new start write wins
    strt_next = strt_reg;
    if (ssen_reg && c.step_done) strt_next = 1'b0;
    if (wr_cst) strt_next = pwdata[B_STRT];
    // only hardware sets the time-out flag; a zero write clears, the set wins
    wdto_next = c.wdt_hit | (wdto_reg & ~(wr_cst & ~pwdata[B_WDTO]));
    ev         = '0;
    ev[I_WDTO] = c.wdt_hit;
    ev[I_TRIG] = c.fire;
    ev[I_STEP] = c.step_done;
    istat_next = istat_reg;
    if (wr && paddr == OFS_ICLR) istat_next = istat_reg & ~pwdata[IRQ_W-1:0];
    istat_next = istat_next | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop counter, watchdog counter, trigger outputs, read mux
  always_comb begin
    lcnt_next = lcnt_reg;
    if (!en_reg) lcnt_next = LIM_RST;
    else if (c.step_done) lcnt_next = (lcnt_reg >= clim_reg) ? LIM_RST : lcnt_reg + 16'h0001;
    wcnt_next = LIM_RST;
    if (c.waiting && !c.halt && !c.wdt_hit) wcnt_next = wcnt_reg + 16'h0001;
    out_next = out_reg;
    for (int i = 0; i < N_IO; i++) begin
      pcnt_next[i] = pcnt_reg[i];
      // an idle halt freezes a running pulse as well, so its width is kept
      if (pcnt_reg[i] != PWD_RST) begin
        if (!c.halt) pcnt_next[i] = pcnt_reg[i] - 8'h01;
      end else if (!togl_reg) out_next[i] = 1'b0;
      if (c.fire && c.fire_idx == ARG_W'(i)) begin
        if (togl_reg) begin
          out_next[i] = ~out_reg[i];
        end else begin
          // high for pulse width + 1 cycles
          out_next[i]  = 1'b1;
          pcnt_next[i] = pwd_reg;
        end
      end
      if (!en_reg) begin
        out_next[i]  = 1'b0;
        pcnt_next[i] = PWD_RST;
      end
    end
    rdata_next = rdata_reg;
    err_next   = 1'b0;
    if (setup) begin
      err_next = ~mapped(paddr);
      case (paddr)
        OFS_CST:   rdata_next = {16'h0000, cst_rd};
        OFS_SDLIM: rdata_next = {16'h0000, ivis_reg ? c.sd_cnt : sdlim_reg};
        OFS_CLIM:  rdata_next = {16'h0000, ivis_reg ? lcnt_reg : clim_reg};
        OFS_TLIM:  rdata_next = {16'h0000, ivis_reg ? c.t_cnt : tlim_reg};
        OFS_WDLIM: rdata_next = {16'h0000, wdlim_reg};
        OFS_PWD:   rdata_next = {24'h000000, pwd_reg};
        OFS_ISTAT: rdata_next = {29'h0000000, istat_reg};
        OFS_IEN:   rdata_next = {29'h0000000, ien_reg};
        OFS_OUT:   rdata_next = {28'h0000000, out_reg};
        default:   rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg    <= 1'b0;
      sidl_reg  <= 1'b0;
      togl_reg  <= 1'b0;
      swt_reg   <= 1'b0;
      ssen_reg  <= 1'b0;
      ivis_reg  <= 1'b0;
      strt_reg  <= 1'b0;
      wdto_reg  <= 1'b0;
      itm_reg   <= 2'h0;
      sdlim_reg <= LIM_RST;
      clim_reg  <= LIM_RST;
      tlim_reg  <= LIM_RST;
      wdlim_reg <= WDLIM_RST;
      pwd_reg   <= PWD_RST;
      istat_reg <= IRQ_RST;
      ien_reg   <= IRQ_RST;
      lcnt_reg  <= LIM_RST;
      wcnt_reg  <= LIM_RST;
      out_reg   <= '0;
      for (int i = 0; i < N_IO; i++) pcnt_reg[i] <= PWD_RST;
      rdata_reg <= 32'h00000000;
      err_reg   <= 1'b0;
    end else begin
      en_reg    <= en_next;
      sidl_reg  <= sidl_next;
      togl_reg  <= togl_next;
      swt_reg   <= swt_next;
      ssen_reg  <= ssen_next;
      ivis_reg  <= ivis_next;
      strt_reg  <= strt_next;
      wdto_reg  <= wdto_next;
      itm_reg   <= itm_next;
      sdlim_reg <= sdlim_next;
      clim_reg  <= clim_next;
      tlim_reg  <= tlim_next;
      wdlim_reg <= wdlim_next;
      pwd_reg   <= pwd_next;
      istat_reg <= istat_next;
      ien_reg   <= ien_next;
      lcnt_reg  <= lcnt_next;
      wcnt_reg  <= wcnt_next;
      out_reg   <= out_next;
      for (int i = 0; i < N_IO; i++) pcnt_reg[i] <= pcnt_next[i];
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end
endmodule

// ==== pkg/tsq_pkg.sv ====
package tsq_pkg;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int CST_W = 16;
  localparam int LIM_W = 16;
  localparam int PWD_W = 8;
  localparam int ARG_W = 2;
  localparam int N_IO  = 4;
  localparam int IRQ_W = 3;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CST   = 8'h00;
  localparam logic [AW-1:0] OFS_SDLIM = 8'h04;
  localparam logic [AW-1:0] OFS_CLIM  = 8'h08;
  localparam logic [AW-1:0] OFS_TLIM  = 8'h0c;
  localparam logic [AW-1:0] OFS_PWD   = 8'h10;
  localparam logic [AW-1:0] OFS_WDLIM = 8'h14;
  localparam logic [AW-1:0] OFS_ISTAT = 8'h18;
  localparam logic [AW-1:0] OFS_ICLR  = 8'h1c;
  localparam logic [AW-1:0] OFS_IEN   = 8'h20;
  localparam logic [AW-1:0] OFS_OUT   = 8'h24;

  // control/status field positions
  localparam int B_EN   = 15;
  localparam int B_SIDL = 13;
  localparam int B_TOGL = 12;
  localparam int B_SWT  = 10;
  localparam int B_SSEN = 9;
  localparam int B_IVIS = 8;
  localparam int B_STRT = 7;
  localparam int B_WDTO = 6;
  localparam int B_ITM  = 0;

  // interrupt status positions
  localparam int I_WDTO = 0;
  localparam int I_TRIG = 1;
  localparam int I_STEP = 2;

  // reset values
  localparam logic [LIM_W-1:0] LIM_RST   = 16'h0000;
  localparam logic [LIM_W-1:0] WDLIM_RST = 16'hffff;
  localparam logic [PWD_W-1:0] PWD_RST   = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 3'h0;

  typedef enum logic [2:0] {
    OP_NOP      = 3'h0,
    OP_TRIG     = 3'h1,
    OP_WHI      = 3'h2,
    OP_WLO      = 3'h3,
    OP_CTRL_SWT = 3'h4,
    OP_TDELAY   = 3'h5
  } tsq_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11,
    ST_STEP  = 2'b10
  } tsq_state_t;
endpackage

// ==== pkg/tsq_ctl_if.sv ====
`timescale 1ns/100ps
interface tsq_ctl_if;
  import tsq_pkg::*;
  logic             en;
  logic             run;
  logic             halt;
  logic [1:0]       in_mode;
  logic [LIM_W-1:0] sd_lim;
  logic [LIM_W-1:0] t_lim;
  logic             swt_pend;
  logic             wdt_hit;
  logic             cmd_valid;
  tsq_op_t          cmd_op;
  logic [ARG_W-1:0] cmd_arg;
  logic [N_IO-1:0]  wait_in;
  logic             cmd_ready;
  logic             swt_take;
  logic             fire;
  logic [ARG_W-1:0] fire_idx;
  logic             waiting;
  logic             step_done;
  logic [LIM_W-1:0] sd_cnt;
  logic [LIM_W-1:0] t_cnt;

  modport reg_side (output en, run, halt, in_mode, sd_lim, t_lim, swt_pend, wdt_hit,
                    cmd_valid, cmd_op, cmd_arg, wait_in,
                    input cmd_ready, swt_take, fire, fire_idx, waiting, step_done,
                    sd_cnt, t_cnt);
  modport exec_side (input en, run, halt, in_mode, sd_lim, t_lim, swt_pend, wdt_hit,
                     cmd_valid, cmd_op, cmd_arg, wait_in,
                     output cmd_ready, swt_take, fire, fire_idx, waiting, step_done,
                     sd_cnt, t_cnt);
endinterface

// ==== rtl/tsq_exec.sv ====
`timescale 1ns/100ps
module tsq_exec (
  input wire logic   pclk,
  input wire logic   presetn,
  tsq_ctl_if.exec_side c
);
  import tsq_pkg::*;

  tsq_state_t       st_reg,  st_next;
  tsq_op_t          op_reg,  op_next;
  logic [ARG_W-1:0] arg_reg, arg_next;
  logic [LIM_W-1:0] sd_reg,  sd_next;
  logic [LIM_W-1:0] t_reg,   t_next;
  logic             lvl_reg, lvl_next;
  logic             sel;
  logic             rise;
  logic             fall;
  logic             skip;

  assign c.fire_idx = arg_reg;
  assign c.sd_cnt   = sd_reg;
  assign c.t_cnt    = t_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next     = st_reg;
    op_next     = op_reg;
    arg_next    = arg_reg;
    sd_next     = sd_reg;
    t_next      = t_reg;
    sel         = c.wait_in[arg_reg];
    lvl_next    = sel;
    // edge mode needs a previous sample; level mode looks at the pin directly
    rise        = c.in_mode[0] ? (sel & ~lvl_reg) : sel;
    fall        = c.in_mode[0] ? (~sel & lvl_reg) : ~sel;
    skip        = c.in_mode[1] && (op_reg == OP_WHI || op_reg == OP_WLO);
    c.cmd_ready = 1'b0;
    c.swt_take  = 1'b0;
    c.fire      = 1'b0;
    c.waiting   = 1'b0;
    c.step_done = 1'b0;
    if (!c.en) begin
      st_next = ST_IDLE;
      sd_next = LIM_RST;
      t_next  = LIM_RST;
    end else if (!c.halt) begin
      case (st_reg)
        ST_IDLE: begin
          if (c.run) st_next = ST_FETCH;
        end
        ST_FETCH: begin
          c.cmd_ready = 1'b1;
          if (c.cmd_valid) begin
            op_next  = c.cmd_op;
            arg_next = c.cmd_arg;
            t_next   = LIM_RST;
            st_next  = ST_EXEC;
          end
        end
        ST_EXEC: begin
          case (op_reg)
            OP_TRIG: begin
              c.fire  = 1'b1;
              st_next = ST_STEP;
            end
            OP_WHI: begin
              c.waiting = 1'b1;
              if (rise || c.wdt_hit) st_next = ST_STEP;
            end
            OP_WLO: begin
              c.waiting = 1'b1;
              if (fall || c.wdt_hit) st_next = ST_STEP;
            end
            OP_CTRL_SWT: begin
              if (c.swt_pend) begin
                c.swt_take = 1'b1;
                st_next    = ST_STEP;
              end
            end
            OP_TDELAY: begin
              t_next = t_reg + 16'h0001;
              if (t_reg >= c.t_lim) st_next = ST_STEP;
            end
            default: st_next = ST_STEP;
          endcase
        end
        ST_STEP: begin
          sd_next = sd_reg + 16'h0001;
          if (skip || sd_reg >= c.sd_lim) begin
            sd_next     = LIM_RST;
            c.step_done = 1'b1;
            st_next     = ST_IDLE;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= ST_IDLE;
      op_reg  <= OP_NOP;
      arg_reg <= '0;
      sd_reg  <= LIM_RST;
      t_reg   <= LIM_RST;
      lvl_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      op_reg  <= op_next;
      arg_reg <= arg_next;
      sd_reg  <= sd_next;
      t_reg   <= t_next;
      lvl_reg <= lvl_next;
    end
  end
endmodule

// ==== test/tsq_top_assertions.sv ====
`timescale 1ns/100ps
module tsq_top_assertions (
  input logic                          pclk,
  input logic                          presetn,
  input logic                          psel,
  input logic                          penable,
  input logic                          pwrite,
  input logic [tsq_pkg::AW-1:0]        paddr,
  input logic [tsq_pkg::DW-1:0]        pwdata,
  input logic [tsq_pkg::DW-1:0]        prdata,
  input logic                          pready,
  input logic                          pslverr,
  input logic                          cmd_valid,
  input logic                          cmd_ready,
  input tsq_pkg::tsq_op_t              cmd_op,
  input logic [tsq_pkg::ARG_W-1:0]     cmd_arg,
  input logic [tsq_pkg::N_IO-1:0]      wait_in,
  input logic                          idle_mode,
  input logic [tsq_pkg::N_IO-1:0]      trig_out,
  input logic                          irq
);
  import tsq_pkg::*;
  // shadow copies of software writes; start may auto-clear inside, so it is only trusted one way
  logic        wr_en;
  logic        rd_acc;
  logic        take_trig;
  logic [15:0] cst_reg, cst_next, sdl_reg, sdl_next;
  logic [7:0]  pwd_reg, pwd_next;
  logic [8:0]  pcnt_reg, pcnt_next;
  logic        wait_reg, wait_next;

  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
    take_trig = cmd_valid && cmd_ready && cmd_op == OP_TRIG;
    cst_next = (wr_en && paddr == OFS_CST) ? pwdata[15:0] : cst_reg;
    sdl_next = (wr_en && paddr == OFS_SDLIM) ? pwdata[15:0] : sdl_reg;
    pwd_next = (wr_en && paddr == OFS_PWD) ? pwdata[7:0] : pwd_reg;
    pcnt_next = (|trig_out) ? pcnt_reg + 9'h1 : 9'h0;
    wait_next = wait_reg || (cmd_valid && cmd_ready && cmd_op inside {OP_WHI, OP_WLO});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_reg <= '0;
      sdl_reg <= '0;
      pwd_reg <= '0;
      pcnt_reg <= '0;
      wait_reg <= 1'b0;
    end else begin
      cst_reg <= cst_next;
      sdl_reg <= sdl_next;
      pwd_reg <= pwd_next;
      pcnt_reg <= pcnt_next;
      wait_reg <= wait_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_trig_take;
    take_trig && cst_reg[B_EN];
  endsequence
  sequence s_halted;
    cst_reg[B_EN] && cst_reg[B_SIDL] && idle_mode;
  endsequence

  a_cst_reserved: assert property (rd_acc && paddr == OFS_CST |->
    prdata[31:16] == 16'h0 && !prdata[14] && !prdata[11] && prdata[5:2] == 4'h0)
    else $error("reserved control bits read nonzero");
  a_wdto_cause: assert property (rd_acc && paddr == OFS_CST && !wait_reg |->
    !prdata[B_WDTO]) else $error("timeout flag set without any wait");
  a_quiet_off: assert property (!cst_reg[B_EN] && !$past(cst_reg[B_EN]) |->
    trig_out == 4'h0 && !cmd_ready) else $error("activity while disabled");
  a_pulse_width: assert property (cst_reg[B_EN] && !cst_reg[B_TOGL] && $fell(|trig_out) |->
    pcnt_reg == {1'b0, pwd_reg} + 9'h1) else $error("pulse width wrong");
  a_toggle_step: assert property (cst_reg[B_EN] && $past(cst_reg[B_EN]) && cst_reg[B_TOGL]
    && $past(cst_reg[B_TOGL]) && trig_out != $past(trig_out)
    |-> $onehot(trig_out ^ $past(trig_out)) && $past(take_trig, 2))
    else $error("toggle output changed without command");
  a_trig_delay: assert property (s_trig_take |-> ##2 trig_out != $past(trig_out))
    else $error("trigger output did not move");
  a_limit_view: assert property (rd_acc && paddr == OFS_SDLIM && !cst_reg[B_IVIS] |->
    prdata == {16'h0, sdl_reg}) else $error("limit read not last write");
  a_live_view: assert property (rd_acc && paddr == OFS_TLIM && cst_reg[B_IVIS]
    && !cst_reg[B_EN] && !$past(cst_reg[B_EN], 3) |-> prdata == 32'h0)
    else $error("live timer not cleared while off");
  a_halt_hold: assert property (s_halted ##1 s_halted |->
    $stable(trig_out) && $stable(cmd_ready)) else $error("moved while idle halted");
  a_start_need: assert property ($rose(cmd_ready) |->
    $past(cst_reg[B_STRT]) && $past(cst_reg[B_EN])) else $error("fetch without start");
endmodule

bind tsq_top tsq_top_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
  .wait_in(wait_in), .idle_mode(idle_mode), .trig_out(trig_out), .irq(irq));

// ==== test/tb_tsq_top.sv ====
`timescale 1ns/100ps
module tb_tsq_top;
  import tsq_pkg::*;
  typedef struct {
    logic [AW-1:0] a;
    logic [DW-1:0] w;
    logic [DW-1:0] r;
    logic          e;
  } tsq_row_t;
  localparam int PW = 2;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]    paddr;
  logic [DW-1:0]    pwdata, prdata, q;
  logic             cmd_valid, cmd_ready, idle_mode, irq, e;
  tsq_op_t          cmd_op;
  logic [ARG_W-1:0] cmd_arg;
  logic [N_IO-1:0]  wait_in, trig_out;
  int               error_cnt, n_tests;
  tsq_row_t         rows[12] = '{
    '{OFS_CST, 32'h7f7b, 32'h3703, 1'b0}, '{OFS_CST, 32'h0, 32'h0400, 1'b0},
    '{OFS_SDLIM, 32'hffff1234, 32'h1234, 1'b0}, '{OFS_CLIM, 32'hbeef, 32'hbeef, 1'b0},
    '{OFS_TLIM, 32'h3, 32'h3, 1'b0}, '{OFS_PWD, 32'h102, 32'h2, 1'b0},
    '{OFS_WDLIM, 32'h20, 32'h20, 1'b0}, '{OFS_ISTAT, 32'h7, 32'h0, 1'b0},
    '{OFS_ICLR, 32'h7, 32'h0, 1'b0}, '{OFS_IEN, 32'hffffffff, 32'h7, 1'b0},
    '{OFS_OUT, 32'hf, 32'h0, 1'b0}, '{8'h40, 32'h5a, 32'h0, 1'b1}};

  tsq_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
    .wait_in(wait_in), .idle_mode(idle_mode), .trig_out(trig_out), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // master waits for pready with no assumed latency; the watchdog bounds it
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_rdy(input int n);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (cmd_ready !== 1'b1 && k < n);
    chk({31'h0, cmd_ready}, 32'h1);
  endtask
  task automatic cmd(input tsq_op_t op, input logic [ARG_W-1:0] g);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= g;
    wait_rdy(300);
    @(posedge pclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, cmd_valid, idle_mode} = 6'h0;
    paddr = '0;
    pwdata = '0;
    cmd_op = OP_NOP;
    cmd_arg = '0;
    wait_in = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("end register table");
    apb(1'b1, OFS_CST, 32'h0100);
    rd(OFS_SDLIM, 32'h0);
    rd(OFS_TLIM, 32'h0);
    apb(1'b1, OFS_CST, 32'h0);
    rd(OFS_TLIM, 32'h3);
    apb(1'b1, OFS_SDLIM, 32'h0);
    apb(1'b1, OFS_PWD, 32'(PW));
    apb(1'b1, OFS_CST, 32'h0080);
    idle_mode <= 1'b1;
    repeat (8) @(negedge pclk);
    chk({27'h0, cmd_ready, trig_out}, 32'h0);
    apb(1'b1, OFS_CST, 32'h8080);
    cmd(OP_TRIG, 2'd1);
    for (int i = 1; i < PW + 4; i++) begin
      @(negedge pclk);
      chk({28'h0, trig_out}, (i > 1 && i < PW + 3) ? 32'h2 : 32'h0);
    end
    rd(OFS_ISTAT, 32'h6);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_CST, 32'h8480);
    apb(1'b1, OFS_IEN, 32'h0);
    cmd(OP_TRIG, 2'd0);
    repeat (8) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IEN, 32'h7);
    apb(1'b1, OFS_ICLR, 32'h7);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("end pulse mode");
    apb(1'b1, OFS_CST, 32'h9080);
    cmd(OP_TRIG, 2'd2);
    repeat (12) @(negedge pclk);
    chk({28'h0, trig_out}, 32'h4);
    cmd(OP_TRIG, 2'd2);
    repeat (3) @(negedge pclk);
    chk({28'h0, trig_out}, 32'h0);
    cmd(OP_CTRL_SWT, 2'd0);
    repeat (6) @(negedge pclk);
    rd(OFS_CST, 32'h9080);
    cmd(OP_CTRL_SWT, 2'd0);
    repeat (20) @(negedge pclk);
    chk({31'h0, cmd_ready}, 32'h0);
    apb(1'b1, OFS_CST, 32'h9480);
    wait_rdy(20);
    rd(OFS_CST, 32'h9080);
    $display("end toggle and software trigger");
    cmd(OP_WHI, 2'd0);
    wait_rdy(300);
    rd(OFS_CST, 32'h90c0);
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    apb(1'b1, OFS_CST, 32'h9080);
    rd(OFS_CST, 32'h9080);
    wait_in <= 4'h1;
    cmd(OP_WHI, 2'd0);
    wait_rdy(20);
    rd(OFS_CST, 32'h9080);
    // edge mode: a pin already high must not end a wait-high, only a fresh rise
    apb(1'b1, OFS_CST, 32'h9081);
    cmd(OP_WHI, 2'd0);
    repeat (4) @(negedge pclk);
    chk({31'h0, cmd_ready}, 32'h0);
    @(posedge pclk);
    wait_in <= 4'h0;
    @(posedge pclk);
    wait_in <= 4'h1;
    wait_rdy(20);
    rd(OFS_CST, 32'h9081);
    $display("end watchdog");
    apb(1'b1, OFS_CST, 32'h0);
    apb(1'b1, OFS_CST, 32'ha080);
    repeat (10) @(negedge pclk);
    chk({31'h0, cmd_ready}, 32'h0);
    @(posedge pclk);
    idle_mode <= 1'b0;
    wait_rdy(10);
    apb(1'b1, OFS_CST, 32'h8280);
    cmd(OP_NOP, 2'd0);
    repeat (10) @(negedge pclk);
    chk({31'h0, cmd_ready}, 32'h0);
    rd(OFS_CST, 32'h8200);
    $display("end idle and single step");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, pready}, 32'h1);
    rd(OFS_CST, 32'h0);
    rd(OFS_ISTAT, 32'h0);
    $display("end mid-run reset");
    summarize();
  end

  // about 350 cycles expected; allow about twenty times that before giving up
  initial begin
    #150us;
    error_cnt++;
    summarize();
  end
endmodule
